// ==== crp_consts.svh ====
// constants for the code read-out protection block
`ifndef CRP_CONSTS_SVH
`define CRP_CONSTS_SVH
// key table and code image sizes
`define CRP_KEY_BYTES    32
`define CRP_CODE_BYTES   4096
`define CRP_KEY_ERASED   8'hFF
// mask image option addresses
`define CRP_IMG_KEY_BASE 13'h1000
`define CRP_IMG_SEC      13'h1020
`define CRP_IMG_WDOG     13'h1030
`define CRP_IMG_RELOAD   13'h1032
// option field positions
`define CRP_SEC1_BIT     0
`define CRP_SEC2_BIT     1
`define CRP_WD_PRE_HI    7
`define CRP_WD_PRE_LO    5
`define CRP_WD_MOD_BIT   0
// boot walk indices
`define CRP_BOOT_SEC_IDX 6'h20
`define CRP_BOOT_WD_IDX  6'h21
`define CRP_BOOT_LAST    6'h22
// register offsets
`define CRP_REG_ADDR_LO  4'h0
`define CRP_REG_ADDR_HI  4'h1
`define CRP_REG_WDATA    4'h2
`define CRP_REG_CMD      4'h3
`define CRP_REG_RDATA    4'h4
`define CRP_REG_STATUS   4'h5
`define CRP_REG_KEY_IDX  4'h6
// command codes
`define CRP_CMD_PROG     8'h01
`define CRP_CMD_KEY      8'h02
`define CRP_CMD_SEC1     8'h03
`define CRP_CMD_SEC2     8'h04
`define CRP_CMD_VERIFY   8'h05
// status bits
`define CRP_ST_REFUSED   3
`endif

// ==== crp_key_table.sv ====
// key table with an encrypt-only output
`timescale 1ns/10ps
`include "crp_consts.svh"
module crp_key_table #(
    parameter int KEY_BYTES = `CRP_KEY_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    crp_link_if.key  lnk
);
    // index width is fixed at five bits
    if (KEY_BYTES != 32) begin : g_bad_size
        $error("crp_key_table: KEY_BYTES must be 32");
    end
    logic [7:0] key_ff [KEY_BYTES]; // key bytes, erased to all ones
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < KEY_BYTES; i++) key_ff[i] <= `CRP_KEY_ERASED;
        end else if (lnk.key_we) begin
            key_ff[lnk.key_widx] <= lnk.key_wdata;
        end
    end
    // key only leaves mixed into code
    assign lnk.cipher = ~(lnk.plain ^ key_ff[lnk.enc_idx]);
    chk_cipher_xnor: assert property (@(posedge clk) disable iff (rst)
        lnk.key_we ##1 (lnk.enc_idx == $past(lnk.key_widx) && !lnk.key_we)
        |-> lnk.cipher == ~(lnk.plain ^ $past(lnk.key_wdata)))
        else $error("cipher is not xnor of key byte");
endmodule // crp_key_table

// ==== crp_link_if.sv ====
// link between protection control, key table and option unit
`timescale 1ns/10ps
interface crp_link_if;
    logic                 key_we;    // key byte write
    logic [4:0]           key_widx;  // key byte index
    logic [7:0]           key_wdata; // key byte value
    logic [4:0]           enc_idx;   // key byte for this read
    logic [7:0]           plain;     // plain code byte
    logic [7:0]           cipher;    // encrypted code byte
    logic                 opt_load;  // option byte strobe
    crp_pkg::crp_opt_type opt_sel;   // which option byte
    logic [7:0]           opt_data;  // option byte value
    logic                 sec1_prog; // program security bit one
    logic                 sec2_prog; // program security bit two
    logic                 sec1;      // security bit one set
    logic                 sec2;      // security bit two set
    logic [2:0]           wd_pre;    // watchdog prescale preset
    logic                 wd_mod;    // watchdog mode preset
    logic [7:0]           wd_reload; // watchdog autoload preset
    modport ctl (output key_we, key_widx, key_wdata, enc_idx, plain, opt_load, opt_sel, opt_data,
                 sec1_prog, sec2_prog, input cipher, sec1, sec2, wd_pre, wd_mod, wd_reload);
    modport key (input key_we, key_widx, key_wdata, enc_idx, plain, output cipher);
    modport opt (input opt_load, opt_sel, opt_data, sec1_prog, sec2_prog,
                 output sec1, sec2, wd_pre, wd_mod, wd_reload);
endinterface

// ==== crp_mem_model.sv ====
// code memory model on the far side of the protection block
`timescale 1ns/10ps
module crp_mem_model (
    input  wire logic        clk,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [12:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [0:8191]; // code image
    logic       rd_ff;        // answer shown this cycle
    // image starts as a known pattern
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'h5A;
        rd_ff = 1'b0;
        mem_rdata = 8'h00;
    end
    // answer one cycle after a read, then show the inverse so stale data never passes
    always @(posedge clk) begin
        rd_ff <= mem_rd;
        if (mem_rd) mem_rdata <= mem[mem_addr];
        else if (rd_ff) mem_rdata <= ~mem_rdata;
        if (mem_wr) mem[mem_addr] <= mem_wdata;
    end
endmodule // crp_mem_model

// ==== crp_option_unit.sv ====
// security bits and watchdog option presets
`timescale 1ns/10ps
`include "crp_consts.svh"
module crp_option_unit (
    input wire logic clk,
    input wire logic rst,
    crp_link_if.opt  lnk
);
    logic       sec1_ff;   // security bit one
    logic       sec2_ff;   // security bit two
    logic [2:0] pre_ff;    // watchdog prescale preset
    logic       mod_ff;    // watchdog mode preset
    logic [7:0] reload_ff; // watchdog autoload preset
    // one-time bits, never cleared by software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sec1_ff <= 1'b0;
            sec2_ff <= 1'b0;
        end else if (lnk.opt_load && lnk.opt_sel == crp_pkg::CRP_OPT_SEC) begin
            sec1_ff <= ~lnk.opt_data[`CRP_SEC1_BIT];
            sec2_ff <= ~lnk.opt_data[`CRP_SEC2_BIT];
        end else begin
            if (lnk.sec1_prog) sec1_ff <= 1'b1;
            if (lnk.sec2_prog) sec2_ff <= 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_ff <= 3'h0;
            mod_ff <= 1'b0;
        end else if (lnk.opt_load && lnk.opt_sel == crp_pkg::CRP_OPT_WDOG) begin
            pre_ff <= lnk.opt_data[`CRP_WD_PRE_HI:`CRP_WD_PRE_LO];
            mod_ff <= lnk.opt_data[`CRP_WD_MOD_BIT];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) reload_ff <= 8'h00;
        else if (lnk.opt_load && lnk.opt_sel == crp_pkg::CRP_OPT_RELOAD) reload_ff <= lnk.opt_data;
    end
    assign lnk.sec1      = sec1_ff;
    assign lnk.sec2      = sec2_ff;
    assign lnk.wd_pre    = pre_ff;
    assign lnk.wd_mod    = mod_ff;
    assign lnk.wd_reload = reload_ff;
    chk_sec_option: assert property (@(posedge clk) disable iff (rst)
        lnk.opt_load && lnk.opt_sel == crp_pkg::CRP_OPT_SEC
        |=> sec1_ff == !$past(lnk.opt_data[0]) && sec2_ff == !$past(lnk.opt_data[1]))
        else $error("security option bits decoded wrongly");
endmodule // crp_option_unit

// ==== crp_pkg.sv ====
// types of the code read-out protection block
package crp_pkg;
    typedef enum logic [1:0] {CRP_BOOT_REQ, CRP_BOOT_CAP, CRP_IDLE, CRP_VCAP} crp_state_type;
    typedef enum logic [1:0] {CRP_OPT_SEC, CRP_OPT_WDOG, CRP_OPT_RELOAD, CRP_OPT_NONE} crp_opt_type;
endpackage

// ==== crp_top.sv ====
// code read-out protection: encrypted verify, security bits, option load
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "crp_consts.svh"
module crp_top #(
    parameter bit MASK_ROM   = 1'b0,
    parameter int CODE_BYTES = `CRP_CODE_BYTES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [12:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        cpu_rd,
    input  wire logic [11:0] cpu_addr,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_rvalid,
    input  wire logic        table_ext_req,
    output logic             table_ext_grant,
    output logic      [2:0]  watchdog_prescale_select,
    output logic             watchdog_mode_select,
    output logic             watchdog_run_control,
    output logic             watchdog_overflow_flag,
    output logic      [7:0]  watchdog_autoload_value
);
    // the image holds no more than the user program
    if (CODE_BYTES < 1 || CODE_BYTES > `CRP_CODE_BYTES) begin : g_bad_code
        $error("crp_top: CODE_BYTES must lie in 1..4096");
    end

    crp_pkg::crp_state_type state_ff;     // sequencer state
    crp_pkg::crp_state_type nxt_state;    // next sequencer state
    logic [11:0]            addr_ff;      // programmer address
    logic [7:0]             wdata_ff;     // programmer write data
    logic [7:0]             rdata_ff;     // last encrypted verify byte
    logic                   rvalid_ff;    // verify byte waiting
    logic [4:0]             enc_idx_ff;   // next key byte to apply
    logic [5:0]             boot_idx_ff;  // option image walk position
    logic                   pend_ff;      // memory command waiting
    logic                   pend_wr_ff;   // waiting command is a write
    logic                   refused_ff;   // sticky refused command
    logic                   key_set_ff;   // key table has been written
    logic                   cpu_pend_ff;  // processor read in flight
    logic                   cpu_rvalid_ff;// processor byte ready
    logic [7:0]             cpu_rdata_ff; // processor byte
    logic [7:0]             reg_rdata_ff; // register read data
    logic                   busy;         // sequencer occupied
    logic                   cmd_wr;       // command register written
    logic                   cmd_ok;       // command may proceed
    logic                   cmd_go;       // accepted command
    logic                   issue;        // waiting command reaches memory
    logic                   boot_cap;     // option byte arrives
    logic                   idx_clr;      // key index reset by software

    crp_link_if lnk ();

    crp_key_table #(
        .KEY_BYTES (`CRP_KEY_BYTES)
    ) u_key (
        .clk (clk),
        .rst (rst),
        .lnk (lnk.key)
    );

    crp_option_unit u_opt (
        .clk (clk),
        .rst (rst),
        .lnk (lnk.opt)
    );

    // image address of each option walk step
    function automatic logic [12:0] boot_addr(input logic [5:0] idx);
        case (idx)
            `CRP_BOOT_SEC_IDX: boot_addr = `CRP_IMG_SEC;
            `CRP_BOOT_WD_IDX:  boot_addr = `CRP_IMG_WDOG;
            `CRP_BOOT_LAST:    boot_addr = `CRP_IMG_RELOAD;
            default:           boot_addr = `CRP_IMG_KEY_BASE + {8'h00, idx[4:0]};
        endcase
    endfunction

    // address lies inside the user program
    function automatic logic in_code(input logic [11:0] a);
        in_code = (32'(a) < CODE_BYTES);
    endfunction

    assign busy     = pend_ff || (state_ff != crp_pkg::CRP_IDLE);
    assign cmd_wr   = reg_wr && (reg_addr == `CRP_REG_CMD);
    assign cmd_go   = cmd_wr && cmd_ok;
    assign issue    = !cpu_rd && pend_ff && (state_ff == crp_pkg::CRP_IDLE);
    assign boot_cap = (state_ff == crp_pkg::CRP_BOOT_CAP);
    assign idx_clr  = reg_wr && (reg_addr == `CRP_REG_KEY_IDX);

    // command acceptance
    always_comb begin
        cmd_ok = 1'b0;
        if (!busy) begin
            case (reg_wdata)
                // code writes only when open and in range
                `CRP_CMD_PROG:   cmd_ok = !MASK_ROM && !lnk.sec1 && in_code(addr_ff);
                // key frozen once bit one is set
                `CRP_CMD_KEY:    cmd_ok = !MASK_ROM && !lnk.sec1;
                // security bits accepted in any order
                `CRP_CMD_SEC1:   cmd_ok = !MASK_ROM;
                `CRP_CMD_SEC2:   cmd_ok = !MASK_ROM;
                // verify depends on bit two only
                `CRP_CMD_VERIFY: cmd_ok = !lnk.sec2 && in_code(addr_ff);
                default:         cmd_ok = 1'b0;
            endcase
        end
    end

    // key table and option unit strobes
    always_comb begin
        // mask key bytes come from the image walk
        lnk.key_we    = (boot_cap && boot_idx_ff < `CRP_BOOT_SEC_IDX) || (cmd_go && reg_wdata == `CRP_CMD_KEY);
        lnk.key_widx  = boot_cap ? boot_idx_ff[4:0] : addr_ff[4:0];
        lnk.key_wdata = boot_cap ? mem_rdata : wdata_ff;
        lnk.enc_idx   = enc_idx_ff;
        lnk.plain     = mem_rdata;
        lnk.opt_load  = boot_cap && boot_idx_ff >= `CRP_BOOT_SEC_IDX;
        lnk.opt_data  = mem_rdata;
        lnk.sec1_prog = cmd_go && reg_wdata == `CRP_CMD_SEC1;
        lnk.sec2_prog = cmd_go && reg_wdata == `CRP_CMD_SEC2;
        case (boot_idx_ff)
            `CRP_BOOT_SEC_IDX: lnk.opt_sel = crp_pkg::CRP_OPT_SEC;
            `CRP_BOOT_WD_IDX:  lnk.opt_sel = crp_pkg::CRP_OPT_WDOG;
            `CRP_BOOT_LAST:    lnk.opt_sel = crp_pkg::CRP_OPT_RELOAD;
            default:           lnk.opt_sel = crp_pkg::CRP_OPT_NONE;
        endcase
    end

    // memory port: processor first, then option walk, then programmer
    always_comb begin
        mem_rd   = 1'b0;
        mem_wr   = 1'b0;
        mem_addr = 13'h0000;
        if (cpu_rd) begin
            mem_rd   = 1'b1;
            mem_addr = {1'b0, cpu_addr};
        end else if (state_ff == crp_pkg::CRP_BOOT_REQ) begin
            mem_rd   = 1'b1;
            mem_addr = boot_addr(boot_idx_ff);
        end else if (issue) begin
            mem_rd   = !pend_wr_ff;
            mem_wr   = pend_wr_ff;
            mem_addr = {1'b0, addr_ff};
        end
    end
    assign mem_wdata = wdata_ff;

    // sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            crp_pkg::CRP_BOOT_REQ: begin
                if (!cpu_rd) nxt_state = crp_pkg::CRP_BOOT_CAP;
            end
            crp_pkg::CRP_BOOT_CAP: begin
                if (boot_idx_ff == `CRP_BOOT_LAST) nxt_state = crp_pkg::CRP_IDLE;
                else nxt_state = crp_pkg::CRP_BOOT_REQ;
            end
            crp_pkg::CRP_IDLE: begin
                if (issue && !pend_wr_ff) nxt_state = crp_pkg::CRP_VCAP;
            end
            crp_pkg::CRP_VCAP: begin
                nxt_state = crp_pkg::CRP_IDLE;
            end
            default: begin
                nxt_state = crp_pkg::CRP_IDLE;
            end
        endcase
    end

    // sequencer state; mask parts walk the option image first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) state_ff <= MASK_ROM ? crp_pkg::CRP_BOOT_REQ : crp_pkg::CRP_IDLE;
        else state_ff <= nxt_state;
    end

    // option walk position
    always_ff @(posedge clk or posedge rst) begin
        if (rst) boot_idx_ff <= 6'h00;
        else if (boot_cap) boot_idx_ff <= boot_idx_ff + 6'h01;
    end

    // programmer address and data registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_ff  <= 12'h000;
            wdata_ff <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == `CRP_REG_ADDR_LO) addr_ff[7:0] <= reg_wdata;
            if (reg_addr == `CRP_REG_ADDR_HI) addr_ff[11:8] <= reg_wdata[3:0];
            if (reg_addr == `CRP_REG_WDATA) wdata_ff <= reg_wdata;
        end
    end

    // waiting memory command, held while the processor reads
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_ff    <= 1'b0;
            pend_wr_ff <= 1'b0;
        end else if (cmd_go && (reg_wdata == `CRP_CMD_PROG || reg_wdata == `CRP_CMD_VERIFY)) begin
            pend_ff    <= 1'b1;
            pend_wr_ff <= (reg_wdata == `CRP_CMD_PROG);
        end else if (issue) begin
            pend_ff    <= 1'b0;
        end
    end

    // verify hands out the encrypted byte only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rdata_ff <= 8'h00;
        else if (state_ff == crp_pkg::CRP_VCAP) rdata_ff <= lnk.cipher;
    end

    // verify byte waiting; a new byte wins over the read clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rvalid_ff <= 1'b0;
        else if (state_ff == crp_pkg::CRP_VCAP) rvalid_ff <= 1'b1;
        else if (reg_rd && reg_addr == `CRP_REG_RDATA) rvalid_ff <= 1'b0;
    end

    // key index steps per read and wraps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) enc_idx_ff <= 5'h00;
        else if (idx_clr) enc_idx_ff <= 5'h00;
        else if (state_ff == crp_pkg::CRP_VCAP) enc_idx_ff <= enc_idx_ff + 5'h01;
    end

    // refused flag; a new refusal wins over the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) refused_ff <= 1'b0;
        else if (cmd_wr && !cmd_ok) refused_ff <= 1'b1;
        else if (reg_wr && reg_addr == `CRP_REG_STATUS && reg_wdata[`CRP_ST_REFUSED]) refused_ff <= 1'b0;
    end

    // key table has been loaded
    always_ff @(posedge clk or posedge rst) begin
        if (rst) key_set_ff <= 1'b0;
        else if (lnk.key_we) key_set_ff <= 1'b1;
    end

    // processor bytes bypass the key entirely
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_pend_ff   <= 1'b0;
            cpu_rvalid_ff <= 1'b0;
            cpu_rdata_ff  <= 8'h00;
        end else begin
            cpu_pend_ff   <= cpu_rd;
            cpu_rvalid_ff <= cpu_pend_ff;
            if (cpu_pend_ff) cpu_rdata_ff <= mem_rdata;
        end
    end
    assign cpu_rdata  = cpu_rdata_ff;
    assign cpu_rvalid = cpu_rvalid_ff;

    // external table reads stop at bit one
    assign table_ext_grant = table_ext_req && !lnk.sec1;

    // watchdog presets; run and overflow are never preset
    assign watchdog_prescale_select = lnk.wd_pre;
    assign watchdog_mode_select     = lnk.wd_mod;
    assign watchdog_run_control     = 1'b0;
    assign watchdog_overflow_flag   = 1'b0;
    assign watchdog_autoload_value  = lnk.wd_reload;

    // register read mux, no key path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CRP_REG_ADDR_LO: reg_rdata_ff <= addr_ff[7:0];
                `CRP_REG_ADDR_HI: reg_rdata_ff <= {4'h0, addr_ff[11:8]};
                `CRP_REG_WDATA:   reg_rdata_ff <= wdata_ff;
                `CRP_REG_RDATA:   reg_rdata_ff <= rdata_ff;
                `CRP_REG_STATUS:  reg_rdata_ff <= {1'b0, rvalid_ff, !(state_ff inside {crp_pkg::CRP_BOOT_REQ,
                                                   crp_pkg::CRP_BOOT_CAP}), key_set_ff, refused_ff,
                                                   lnk.sec2, lnk.sec1, busy};
                `CRP_REG_KEY_IDX: reg_rdata_ff <= {3'h0, enc_idx_ff};
                default:          reg_rdata_ff <= 8'h00;
            endcase
        end else begin
            reg_rdata_ff <= 8'h00;
        end
    end
    assign reg_rdata = reg_rdata_ff;

    chk_table_gate: assert property (@(posedge clk) disable iff (rst)
        table_ext_grant |-> table_ext_req && !lnk.sec1)
        else $error("external table read granted while locked");
    chk_prog_refuse: assert property (@(posedge clk) disable iff (rst)
        cmd_wr && reg_wdata inside {`CRP_CMD_PROG, `CRP_CMD_KEY} && lnk.sec1
        |-> !lnk.key_we ##1 refused_ff && !(pend_ff && pend_wr_ff))
        else $error("programming taken while bit one set");
    chk_sec2_accept: assert property (@(posedge clk) disable iff (rst)
        cmd_wr && reg_wdata == `CRP_CMD_SEC2 && !busy && !MASK_ROM && lnk.sec1
        |=> lnk.sec2 && refused_ff == $past(refused_ff))
        else $error("bit two not taken after bit one");
    chk_verify_open: assert property (@(posedge clk) disable iff (rst)
        cmd_wr && reg_wdata == `CRP_CMD_VERIFY && !busy && !lnk.sec2 && in_code(addr_ff) && !cpu_rd
        |=> !cpu_rd |=> state_ff == crp_pkg::CRP_VCAP ##1 rvalid_ff)
        else $error("verify blocked with only bit one set");
    chk_verify_block: assert property (@(posedge clk) disable iff (rst)
        cmd_wr && reg_wdata == `CRP_CMD_VERIFY && lnk.sec2
        |=> refused_ff && !(pend_ff && !pend_wr_ff) ##1 state_ff != crp_pkg::CRP_VCAP)
        else $error("verify ran with bit two set");
    chk_key_order: assert property (@(posedge clk) disable iff (rst)
        state_ff == crp_pkg::CRP_VCAP && !idx_clr |=> enc_idx_ff == $past(enc_idx_ff) + 5'h01)
        else $error("key index did not step per read");
    chk_key_wrap: assert property (@(posedge clk) disable iff (rst)
        state_ff == crp_pkg::CRP_VCAP && enc_idx_ff == 5'h1F |=> enc_idx_ff == 5'h00)
        else $error("key index did not wrap to zero");
    chk_cpu_plain: assert property (@(posedge clk) disable iff (rst)
        cpu_rd |=> ##1 cpu_rvalid && cpu_rdata == $past(mem_rdata))
        else $error("processor byte altered");
    chk_boot_addr: assert property (@(posedge clk) disable iff (rst)
        state_ff == crp_pkg::CRP_BOOT_REQ && !cpu_rd && boot_idx_ff < `CRP_BOOT_SEC_IDX
        |-> mem_rd && mem_addr == `CRP_IMG_KEY_BASE + {8'h00, boot_idx_ff[4:0]})
        else $error("key image address wrong");
endmodule // crp_top

// ==== testbench.sv ====
// self-checking bench for the code read-out protection block
`timescale 1ns/10ps
`include "crp_consts.svh"
module testbench;
    logic        clk, rst, reg_wr, reg_rd, cpu_rd, treq, mem_rd, mem_wr, cpu_rvalid, grant, wd_mod, wd_run, wd_ovf;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, mem_rdata, mem_wdata, cpu_rdata, wd_rel, v;
    logic [12:0] mem_addr;
    logic [11:0] cpu_addr, a;
    logic [2:0]  wd_pre;
    logic [7:0]  key [0:31];
    // mask variant beside the programmable one
    logic        m_rd, m_wr, m_vld, m_grant, m_mod, m_run, m_ovf;
    logic [7:0]  m_rdata, m_mrdata, m_wdata, m_cdata, m_rel, vm;
    logic [12:0] m_addr;
    logic [2:0]  m_pre;
    int          num_errors = 0, samples_checked = 0, seed = 32'h1d8e6c52;
    crp_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .table_ext_req(treq), .table_ext_grant(grant),
        .watchdog_prescale_select(wd_pre), .watchdog_mode_select(wd_mod), .watchdog_run_control(wd_run),
        .watchdog_overflow_flag(wd_ovf), .watchdog_autoload_value(wd_rel));
    crp_mem_model mem_u (.clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    crp_top #(.MASK_ROM(1'b1)) dut_m (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(m_rdata), .mem_rd(m_rd), .mem_wr(m_wr), .mem_addr(m_addr),
        .mem_wdata(m_wdata), .mem_rdata(m_mrdata), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_rdata(m_cdata),
        .cpu_rvalid(m_vld), .table_ext_req(treq), .table_ext_grant(m_grant), .watchdog_prescale_select(m_pre),
        .watchdog_mode_select(m_mod), .watchdog_run_control(m_run), .watchdog_overflow_flag(m_ovf),
        .watchdog_autoload_value(m_rel));
    crp_mem_model mem_m (.clk(clk), .mem_rd(m_rd), .mem_wr(m_wr), .mem_addr(m_addr), .mem_wdata(m_wdata),
        .mem_rdata(m_mrdata));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // plain image byte as the bench expects it
    function automatic logic [7:0] img(input logic [11:0] ad);
        return (ad == 12'h010) ? 8'hC3 : (ad[7:0] ^ 8'h5A);
    endfunction
    task automatic print_verdict;
        if (num_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        vm = m_rdata;
    endtask
    // every level uses one write sequence
    task automatic cmd(input logic [11:0] ad, input logic [7:0] c);
        wr(`CRP_REG_ADDR_LO, ad[7:0]);
        wr(`CRP_REG_ADDR_HI, {4'h0, ad[11:8]});
        wr(`CRP_REG_CMD, c);
    endtask
    // poll a status bit under a bound
    task automatic waitst(input int b, input logic val);
        int n;
        n = 0;
        rd(`CRP_REG_STATUS);
        while (v[b] !== val && n < 20) begin
            rd(`CRP_REG_STATUS);
            n++;
        end
        if (v[b] !== val) begin
            num_errors++;
            print_verdict;
        end
    endtask
    task automatic vfy(input logic [11:0] ad, input logic [4:0] j);
        cmd(ad, `CRP_CMD_VERIFY);
        waitst(6, 1'b1);
        rd(`CRP_REG_RDATA);
        chk("verify byte", v, ~(img(ad) ^ key[j]));
        // mask key byte j is j^5AH in the image, plain byte is ad^5AH
        chk("mask verify byte", vm, ~(ad[7:0] ^ {3'h0, j}));
    endtask
    // hang guard
    initial begin
        #1000000;
        num_errors++;
        print_verdict;
    end
    initial begin
        {reg_wr, reg_rd, cpu_rd, reg_addr, reg_wdata, cpu_addr} = '0;
        treq = 1'b1;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(4'hF); chk("unmapped read", v, 8'h00);
        rd(`CRP_REG_KEY_IDX); chk("key index", v, 8'h00);
        #1 chk("table grant", {7'h0, grant}, 8'h01);
        wr(`CRP_REG_WDATA, 8'hC3);
        cmd(12'h010, `CRP_CMD_PROG);
        waitst(0, 1'b0);
        for (int k = 0; k < 32; k++) begin
            key[k] = 8'($random(seed));
            wr(`CRP_REG_WDATA, key[k]);
            cmd(k[11:0], `CRP_CMD_KEY);
        end
        // 34 reads so the key index wraps
        for (int i = 0; i < 34; i++) begin
            a = (i == 0) ? 12'h010 : 12'($random(seed));
            vfy(a, 5'(i));
        end
        @(posedge clk);
        cpu_rd <= 1'b1; cpu_addr <= 12'h010;
        @(posedge clk);
        cpu_rd <= 1'b0;
        @(posedge clk);
        #1 chk("fetch valid", {7'h0, cpu_rvalid}, 8'h01);
        chk("fetch byte", cpu_rdata, 8'hC3);
        chk("mask fetch valid", {7'h0, m_vld}, 8'h01);
        chk("mask fetch byte", m_cdata, 8'h10 ^ 8'h5A);
        cmd(12'h000, `CRP_CMD_SEC1);
        rd(`CRP_REG_STATUS); chk("sec1 bit", v & 8'h02, 8'h02);
        // mask image 1020H is 7AH: bit one set, bit two clear
        chk("mask status", vm & 8'h36, 8'h32);
        chk("table grant", {7'h0, grant}, 8'h00);
        chk("mask table grant", {7'h0, m_grant}, 8'h00);
        wr(`CRP_REG_STATUS, 8'h08);
        cmd(12'h020, `CRP_CMD_PROG);
        rd(`CRP_REG_STATUS); chk("prog refused", v & 8'h08, 8'h08);
        wr(`CRP_REG_STATUS, 8'h08);
        cmd(12'h000, `CRP_CMD_KEY);
        rd(`CRP_REG_STATUS); chk("key refused", v & 8'h08, 8'h08);
        a = 12'($random(seed));
        vfy(a, 5'h02);
        cmd(12'h000, `CRP_CMD_SEC2);
        rd(`CRP_REG_STATUS); chk("sec2 bit", v & 8'h06, 8'h06);
        chk("mask sec2 bit", vm & 8'h04, 8'h00);
        wr(`CRP_REG_STATUS, 8'h08);
        cmd(a, `CRP_CMD_VERIFY);
        rd(`CRP_REG_STATUS); chk("verify refused", v & 8'h48, 8'h08);
        chk("watchdog fixed bits", {4'h0, m_run, m_ovf, wd_run, wd_ovf}, 8'h00);
        chk("watchdog presets", {wd_pre, 4'h0, wd_mod}, 8'h00);
        chk("watchdog reload", wd_rel, 8'h00);
        // mask image 1030H is 6AH, 1032H is 68H
        chk("mask presets", {m_pre, 4'h0, m_mod}, 8'h6A & 8'hE1);
        chk("mask reload", m_rel, 8'h68);
        print_verdict;
    end
endmodule // testbench
